// ### fsb_regs.vh
`ifndef FSB_REGS_VH
`define FSB_REGS_VH
`define FSB_ADDR_W 33
`define FSB_REQ_W 5
`define FSB_LO_W 14
`define FSB_A20_IDX 17
`define FSB_SYS_NS 50
`define FSB_BCLK_HALF_NS 200
`define FSB_HALF_CYC (`FSB_BCLK_HALF_NS / `FSB_SYS_NS)
`define FSB_SYNC_W 44
`define FSB_ST_IDLE 2'h0
`define FSB_ST_WAIT 2'h1
`define FSB_ST_PH1 2'h2
`define FSB_ST_PH2 2'h3
`endif

// ### fsb_sync2.v
`timescale 1ns/100ps
module fsb_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk_sys, // System clock
  input wire rst, // Async reset
  input wire [W-1:0] d, // Asynchronous inputs
  output wire [W-1:0] q // Synchronised inputs
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          meta_q <= INIT[i];
          sync_q <= INIT[i];
        end
        else
        begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule // fsb_sync2

// ### fsb_req_phase.v
`timescale 1ns/100ps
`include "fsb_regs.vh"
module fsb_req_phase (
  input wire clk_sys, // 20 MHz system clock
  input wire rst, // Async reset, active high
  input wire bclk, // Bus clock from pin
  input wire bus_reset_n, // Bus reset pin
  input wire addr_bit20_mask_n, // Bit-20 mask pin
  input wire [`FSB_ADDR_W-1:0] addr_in_n, // Address lines, pin level
  output reg [`FSB_ADDR_W-1:0] addr_out_n, // Address lines, driven level
  output reg addr_oe, // Address lines drive enable
  input wire [`FSB_REQ_W-1:0] req_code_in_n, // Request code, pin level
  output reg [`FSB_REQ_W-1:0] req_code_out_n, // Request code, driven level
  output reg req_code_oe, // Request code drive enable
  input wire addr_strobe_valid_in_n, // Address strobe valid, pin level
  output reg addr_strobe_valid_out_n, // Address strobe valid, driven level
  output reg addr_strobe_valid_oe, // Address strobe valid drive enable
  input wire [1:0] addr_source_strobe_in_n, // Source strobes, pin level
  output reg [1:0] addr_source_strobe_out_n, // Source strobes, driven level
  output reg addr_source_strobe_oe, // Source strobes drive enable
  input wire tx_req, // Request to issue a transaction
  input wire [`FSB_ADDR_W-1:0] tx_addr, // Physical address bits 35:3
  input wire [`FSB_ADDR_W-1:0] tx_type, // Sub-phase two type information
  input wire [`FSB_REQ_W-1:0] tx_code1, // Request code, sub-phase one
  input wire [`FSB_REQ_W-1:0] tx_code2, // Request code, sub-phase two
  output reg tx_busy, // Transaction in progress
  input wire [`FSB_ADDR_W-1:0] lookup_addr_in, // Address for cache lookup
  output reg [`FSB_ADDR_W-1:0] lookup_addr, // Masked lookup address
  output reg rx_start, // New transaction seen, one pulse
  output reg rx_valid, // Both sub-phases captured, one pulse
  output reg [`FSB_ADDR_W-1:0] rx_addr, // Captured address
  output reg [`FSB_ADDR_W-1:0] rx_type, // Captured type information
  output reg [`FSB_REQ_W-1:0] rx_code1, // Captured request code, phase one
  output reg [`FSB_REQ_W-1:0] rx_code2, // Captured request code, phase two
  output reg [`FSB_ADDR_W-1:0] strap_q // Straps held after bus reset
);
  wire [`FSB_SYNC_W-1:0] sync_in;
  wire [`FSB_SYNC_W-1:0] sync_out;
  wire [`FSB_ADDR_W-1:0] addr_s_n;
  wire [`FSB_REQ_W-1:0] code_s_n;
  wire valid_s_n;
  wire [1:0] stb_s_n;
  wire bclk_s;
  wire bus_reset_s_n;
  wire mask_s_n;
  reg bclk_p_q;
  reg [1:0] stb_p_q;
  reg [1:0] st_q;
  reg [2:0] cnt_q;
  reg [`FSB_ADDR_W-1:0] tx_addr_q;
  reg [`FSB_ADDR_W-1:0] tx_type_q;
  reg [`FSB_REQ_W-1:0] tx_code1_q;
  reg [`FSB_REQ_W-1:0] tx_code2_q;
  reg rx_ph1_q;
  reg [2:0] own_q;
  wire bclk_rise;
  wire [1:0] stb_fall;
  wire [1:0] stb_rise;
  wire half_done;
  wire rx_en;
  localparam [1:0] ST_IDLE = `FSB_ST_IDLE;
  localparam [1:0] ST_WAIT = `FSB_ST_WAIT;
  localparam [1:0] ST_PH1 = `FSB_ST_PH1;
  localparam [1:0] ST_PH2 = `FSB_ST_PH2;

  // Clears bit 20 while the mask is asserted
  function [`FSB_ADDR_W-1:0] mask_a20;
    input [`FSB_ADDR_W-1:0] a;
    input mask_n;
    begin
      mask_a20 = a;
      if (!mask_n)
        mask_a20[`FSB_A20_IDX] = 1'b0;
    end
  endfunction

  assign sync_in = {addr_in_n, req_code_in_n, addr_strobe_valid_in_n, addr_source_strobe_in_n,
                    bclk, bus_reset_n, addr_bit20_mask_n};
  fsb_sync2 #(
    .W(`FSB_SYNC_W),
    .INIT({`FSB_SYNC_W{1'b1}})
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(sync_in),
    .q(sync_out)
  );
  assign addr_s_n = sync_out[43:11];
  assign code_s_n = sync_out[10:6];
  assign valid_s_n = sync_out[5];
  assign stb_s_n = sync_out[4:3];
  assign bclk_s = sync_out[2];
  assign bus_reset_s_n = sync_out[1];
  assign mask_s_n = sync_out[0];

  assign bclk_rise = bclk_s & ~bclk_p_q;
  assign stb_fall = stb_p_q & ~stb_s_n;
  assign stb_rise = ~stb_p_q & stb_s_n;
  assign half_done = (cnt_q == (`FSB_HALF_CYC - 1));
  // Own drive still echoes through the synchronisers after release
  assign rx_en = ~tx_busy & ~|own_q;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bclk_p_q <= 1'b1;
      stb_p_q <= 2'h3;
      lookup_addr <= {`FSB_ADDR_W{1'b0}};
      strap_q <= {`FSB_ADDR_W{1'b0}};
    end
    else
    begin
      bclk_p_q <= bclk_s;
      stb_p_q <= stb_s_n;
      lookup_addr <= mask_a20(lookup_addr_in, mask_s_n);
      if (!bus_reset_s_n)
        strap_q <= ~addr_s_n;
    end
  end

  // Transmit: address then type, strobes edge each half
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      tx_busy <= 1'b0;
      tx_addr_q <= {`FSB_ADDR_W{1'b0}};
      tx_type_q <= {`FSB_ADDR_W{1'b0}};
      tx_code1_q <= {`FSB_REQ_W{1'b0}};
      tx_code2_q <= {`FSB_REQ_W{1'b0}};
      addr_out_n <= {`FSB_ADDR_W{1'b1}};
      addr_oe <= 1'b0;
      req_code_out_n <= {`FSB_REQ_W{1'b1}};
      req_code_oe <= 1'b0;
      addr_strobe_valid_out_n <= 1'b1;
      addr_strobe_valid_oe <= 1'b0;
      addr_source_strobe_out_n <= 2'h3;
      addr_source_strobe_oe <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (tx_req && bus_reset_s_n)
          begin
            tx_addr_q <= mask_a20(tx_addr, mask_s_n);
            tx_type_q <= tx_type;
            tx_code1_q <= tx_code1;
            tx_code2_q <= tx_code2;
            tx_busy <= 1'b1;
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (bclk_rise)
          begin
            addr_out_n <= ~tx_addr_q;
            req_code_out_n <= ~tx_code1_q;
            addr_strobe_valid_out_n <= 1'b0;
            addr_source_strobe_out_n <= 2'h3;
            addr_oe <= 1'b1;
            req_code_oe <= 1'b1;
            addr_strobe_valid_oe <= 1'b1;
            addr_source_strobe_oe <= 1'b1;
            cnt_q <= 3'h0;
            st_q <= ST_PH1;
          end
        end
        ST_PH1:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (half_done)
            addr_source_strobe_out_n <= 2'h0;
          if (cnt_q == `FSB_HALF_CYC)
          begin
            addr_out_n <= ~tx_type_q;
            req_code_out_n <= ~tx_code2_q;
            cnt_q <= 3'h0;
            st_q <= ST_PH2;
          end
        end
        default:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (half_done)
            addr_source_strobe_out_n <= 2'h3;
          if (cnt_q == `FSB_HALF_CYC)
          begin
            addr_out_n <= {`FSB_ADDR_W{1'b1}};
            req_code_out_n <= {`FSB_REQ_W{1'b1}};
            addr_strobe_valid_out_n <= 1'b1;
            addr_oe <= 1'b0;
            req_code_oe <= 1'b0;
            addr_strobe_valid_oe <= 1'b0;
            addr_source_strobe_oe <= 1'b0;
            tx_busy <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive: other agent's request, ignored while driving
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rx_start <= 1'b0;
      rx_valid <= 1'b0;
      rx_ph1_q <= 1'b0;
      own_q <= 3'h0;
      rx_addr <= {`FSB_ADDR_W{1'b0}};
      rx_type <= {`FSB_ADDR_W{1'b0}};
      rx_code1 <= {`FSB_REQ_W{1'b0}};
      rx_code2 <= {`FSB_REQ_W{1'b0}};
    end
    else
    begin
      own_q <= {own_q[1:0], addr_oe};
      rx_start <= bclk_rise & ~valid_s_n & rx_en;
      rx_valid <= 1'b0;
      if (rx_en)
      begin
        if (stb_fall[0])
        begin
          rx_addr[`FSB_LO_W-1:0] <= ~addr_s_n[`FSB_LO_W-1:0];
          rx_code1 <= ~code_s_n;
          rx_ph1_q <= 1'b1;
        end
        if (stb_fall[1])
          rx_addr[`FSB_ADDR_W-1:`FSB_LO_W] <= ~addr_s_n[`FSB_ADDR_W-1:`FSB_LO_W];
        if (stb_rise[0])
        begin
          rx_type[`FSB_LO_W-1:0] <= ~addr_s_n[`FSB_LO_W-1:0];
          rx_code2 <= ~code_s_n;
          rx_valid <= rx_ph1_q;
          rx_ph1_q <= 1'b0;
        end
        if (stb_rise[1])
          rx_type[`FSB_ADDR_W-1:`FSB_LO_W] <= ~addr_s_n[`FSB_ADDR_W-1:`FSB_LO_W];
      end
    end
  end
endmodule // fsb_req_phase

// ### fsb_req_phase_assertions.sv
`timescale 1ns/100ps
module fsb_req_phase_chk (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire bus_reset_n, // Bus reset
  input wire addr_bit20_mask_n, // Mask pin
  input wire [32:0] lookup_addr_in, // Lookup in
  input wire [32:0] lookup_addr, // Lookup out
  input wire [32:0] addr_out_n, // Driven address
  input wire addr_oe, // Address enable
  input wire addr_strobe_valid_out_n, // Valid strobe
  input wire [1:0] addr_source_strobe_out_n, // Strobes
  input wire tx_req, // Request
  input wire tx_busy, // Busy
  input wire rx_start, // Start pulse
  input wire rx_valid, // Valid pulse
  input wire [32:0] strap_q // Straps
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ph1_s;
    ##1 $stable(addr_out_n)[*4];
  endsequence
  sequence stb_s;
    (addr_source_strobe_out_n == 2'h3)[*4] ##1 addr_source_strobe_out_n == 2'h0;
  endsequence
  addr_hold_a: assert property ($rose(addr_oe) |-> ph1_s)
    else $error("address moved in phase one");
  strobe_fall_a: assert property ($rose(addr_oe) |-> stb_s)
    else $error("strobes fell at wrong time");
  strobe_rise_a: assert property ($fell(addr_source_strobe_out_n[0]) |->
    (addr_source_strobe_out_n == 2'h0)[*5] ##1 addr_source_strobe_out_n == 2'h3)
    else $error("strobes rose at wrong time");
  drive_len_a: assert property ($rose(addr_oe) |->
    (addr_oe && !addr_strobe_valid_out_n)[*8] ##1 addr_oe[*2] ##1 (!addr_oe && !tx_busy))
    else $error("drive window wrong");
  busy_cause_a: assert property ($rose(tx_busy) |-> $past(tx_req))
    else $error("busy without request");
  rx_quiet_a: assert property (rx_start |-> !tx_busy)
    else $error("receive start while busy");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("valid pulse too long");
  mask_on_a: assert property ((!addr_bit20_mask_n)[*4] |=>
    lookup_addr == ($past(lookup_addr_in) & ~(33'h1 << 17)))
    else $error("bit 20 not masked");
  mask_off_a: assert property (addr_bit20_mask_n[*4] |=> lookup_addr == $past(lookup_addr_in))
    else $error("lookup address altered");
  strap_hold_a: assert property (bus_reset_n[*4] |=> $stable(strap_q))
    else $error("straps changed after reset");
endmodule // fsb_req_phase_chk
bind fsb_req_phase fsb_req_phase_chk i_fsb_req_phase_chk (.*);

// ### fsb_agent_model.sv
`timescale 1ns/100ps
module fsb_agent_model (
  output reg bclk, // Bus clock
  output reg m_drv, // Agent drives the lines
  output reg [32:0] m_a, // Address lines, low active
  output reg [4:0] m_c, // Request code, low active
  output reg m_valid, // Valid strobe, low active
  output reg [1:0] m_stb // Source strobes, low active
);
  initial
  begin
    bclk = 1'b0;
    m_drv = 1'b0;
    m_a = 33'h0;
    m_c = 5'h0;
    m_valid = 1'b1;
    m_stb = 2'h3;
  end
  always #200 bclk = ~bclk;
  task hold(input [32:0] v);
    begin
      m_drv = 1'b1;
      m_a = ~v;
    end
  endtask
  task send(input [32:0] ad, input [32:0] ty, input [4:0] k1, input [4:0] k2);
    begin
      @(posedge bclk);
      m_drv = 1'b1;
      m_valid = 1'b0;
      m_a = ~ad;
      m_c = ~k1;
      @(negedge bclk);
      m_stb = 2'h0;
      @(posedge bclk);
      m_valid = 1'b1;
      m_a = ~ty;
      m_c = ~k2;
      @(negedge bclk);
      m_stb = 2'h3;
      @(posedge bclk);
      m_drv = 1'b0;
    end
  endtask
endmodule // fsb_agent_model

// ### fsb_req_phase_tb_top.sv
`timescale 1ns/100ps
module fsb_req_phase_tb_top;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg bus_reset_n = 1'b0;
  reg addr_bit20_mask_n = 1'b1;
  reg tx_req = 1'b0;
  reg [32:0] tx_addr = 33'h0;
  reg [32:0] tx_type = 33'h0;
  reg [4:0] tx_code1 = 5'h0;
  reg [4:0] tx_code2 = 5'h0;
  reg [32:0] lookup_addr_in = 33'h0;
  wire [32:0] addr_in_n, addr_out_n, lookup_addr, rx_addr, rx_type, strap_q, m_a;
  wire [4:0] req_code_in_n, req_code_out_n, rx_code1, rx_code2, m_c;
  wire [1:0] addr_source_strobe_in_n, addr_source_strobe_out_n, m_stb;
  wire bclk, m_drv, m_valid, addr_oe, req_code_oe, addr_strobe_valid_in_n, addr_strobe_valid_out_n;
  wire addr_strobe_valid_oe, addr_source_strobe_oe, tx_busy, rx_start, rx_valid;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_start = 0;
  // Undriven lines float to the pull-up level
  assign addr_in_n = addr_oe ? addr_out_n : m_drv ? m_a : {33{1'b1}};
  assign req_code_in_n = req_code_oe ? req_code_out_n : m_drv ? m_c : 5'h1F;
  assign addr_strobe_valid_in_n = addr_strobe_valid_oe ? addr_strobe_valid_out_n : m_drv ? m_valid : 1'b1;
  assign addr_source_strobe_in_n = addr_source_strobe_oe ? addr_source_strobe_out_n : m_drv ? m_stb : 2'h3;
  always #25 clk_sys = ~clk_sys;
  // Counts receive-start pulses over the whole run
  always @(posedge clk_sys)
    if (rx_start === 1'b1)
      n_start <= n_start + 1;
  fsb_req_phase i_fsb_req_phase (.*);
  fsb_agent_model i_fsb_agent_model (.*);
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [32:0] e, input [32:0] g);
    begin
      n_checks++;
      if (g !== e)
      begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  function bit cond(input int k);
    case (k)
      0: cond = addr_source_strobe_in_n[0] === 1'b0;
      1: cond = addr_source_strobe_in_n[0] === 1'b1;
      2: cond = rx_valid === 1'b1;
      3: cond = tx_busy === 1'b1;
      default: cond = tx_busy === 1'b0;
    endcase
  endfunction
  task wait_for(input int k);
    int i;
    begin
      for (i = 0; i < 400 && !cond(k); i++) @(posedge clk_sys) #1;
      if (!cond(k))
      begin
        n_mismatch++;
        $display("Error wait %0d expected 1 seen 0", k);
        report_and_stop;
      end
    end
  endtask
  task send_tx(input [32:0] a, input [32:0] t, input [4:0] k1, input [4:0] k2, input [32:0] ea);
    begin
      @(posedge clk_sys);
      tx_addr <= a;
      tx_type <= t;
      tx_code1 <= k1;
      tx_code2 <= k2;
      tx_req <= 1'b1;
      wait_for(3);
      @(posedge clk_sys);
      tx_req <= 1'b0;
      wait_for(0);
      chk("addr one", ~ea, addr_in_n);
      chk("code one", {~k1}, {req_code_in_n});
      chk("valid strobe", 33'h0, {addr_strobe_valid_in_n});
      wait_for(1);
      chk("addr two", ~t, addr_in_n);
      chk("code two", {~k2}, {req_code_in_n});
      wait_for(4);
    end
  endtask
  task t_tx;
    begin
      send_tx(33'h1_5555_AAAA, 33'h0_F0F0_0F0F, 5'h0A, 5'h15, 33'h1_5555_AAAA);
      send_tx(33'h0_AAAA_5555, 33'h1_0F0F_F0F0, 5'h1F, 5'h00, 33'h0_AAAA_5555);
      chk("rx start idle", 33'h0, n_start);
      $display("transmit test done");
    end
  endtask
  task t_a20;
    begin
      @(posedge clk_sys);
      addr_bit20_mask_n <= 1'b0;
      lookup_addr_in <= 33'h1_FFFF_FFFF;
      repeat (5) @(posedge clk_sys);
      #1 chk("lookup masked", 33'h1_FFFD_FFFF, lookup_addr);
      send_tx(33'h1_FFFF_FFFF, 33'h0_0000_0001, 5'h01, 5'h02, 33'h1_FFFD_FFFF);
      @(posedge clk_sys);
      addr_bit20_mask_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 chk("lookup clear", 33'h1_FFFF_FFFF, lookup_addr);
      $display("mask test done");
    end
  endtask
  task t_rx;
    begin
      fork
        i_fsb_agent_model.send(33'h0_1234_5678, 33'h1_0F0F_F0F0, 5'h03, 5'h1C);
        wait_for(2);
      join
      chk("rx start", 33'h1, n_start);
      chk("rx addr", 33'h0_1234_5678, rx_addr);
      chk("rx type", 33'h1_0F0F_F0F0, rx_type);
      chk("rx code one", 33'h3, {rx_code1});
      chk("rx code two", 33'h1C, {rx_code2});
      $display("receive test done");
    end
  endtask
  initial
  begin
    @(posedge clk_sys);
    i_fsb_agent_model.hold(33'h1_2345_6789);
    repeat (7) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bus_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 i_fsb_agent_model.m_drv = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk("straps", 33'h1_2345_6789, strap_q);
    $display("strap test done");
    t_tx;
    t_a20;
    t_rx;
    report_and_stop;
  end
endmodule // fsb_req_phase_tb_top
